/* File: core/fcsu_top.v */
// Flash command launch and status unit with AHB-Lite register slave
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
// Function
// - Status bits 3,1,0 read zero, unwritable
// - Writing one to empty flag launches command
// - Empty flag sets on burst handoff
// - Only burst commands queue behind busy
// - Empty flag zero means buffer full
// - Complete flag sets when idle, empty
// - Complete clears on valid launch, unwritable
// - Protected target sets violation, discards command
// - Violation clears only by writing one
// - Access error for sequence, divider, stop
// - Access error cleared by writing one
// - Blank check sets blank when erased
// - Blank clears on valid launch, unwritable
// - Blank one means array all FF
// - Decode 05 blank, 20 byte program
// - Decode 25 as burst byte program
// - Decode 40 page, 41 whole erase
// - Unknown codes give access error
// - Key window writes start sequence only outside key mode
// - Open bit zero protects whole array
//
// Register map, one 32-bit word per register, data in the low bits:
//   status   flags: empty, complete, violation, access error, blank
//   command  8-bit command code, loaded before the launch write
//   config   bit 0 divider set, bit 1 key-write mode
//   protect  bit 0 open, bit 1 protection disable, [15:8] start page
//   array    array write: [31:16] target address, [7:0] data byte
//   stop     any write while a command runs models stop entry
//
// Software flow: array write, command write, then write one to the
// empty flag. Anything else raises the access error and is dropped.
// Only burst programs may sit in the one-deep command buffer behind a
// running burst; every other code is refused while the array is busy.
//
// Limitation: busy times are fixed cycle counts, not a model of the
// real array timing, so software must poll the complete flag.
//
`include "fcsu_defs.vh"
module fcsu_top #(
   parameter ADDR_W = 16
) (
   input wire MCLK,
   input wire SYS_RST,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output wire [31:0] HRDATA,
   output wire HREADYOUT,
   output wire HRESP,
   output wire ARRAY_START,
   output wire [7:0] ARRAY_CMD,
   output wire [ADDR_W-1:0] ARRAY_ADDR,
   output wire [7:0] ARRAY_DATA,
   input wire ARRAY_ERASED,
   output wire ARRAY_BUSY
);
   // Sequence phases
   localparam SEQ_IDLE = 2'd0;
   localparam SEQ_DATA = 2'd1;
   localparam SEQ_CMD = 2'd2;

   ////////////////////////////////////////////////////////////////////////////
   // Command helpers
   // Decoding is shared by the launch checks and the queue handoff, so it
   // lives in functions to keep both paths in step.
   // Legal code set
   function is_legal;
      input [7:0] c;
      begin
         is_legal = (c == `FCSU_CMD_BLANK) || (c == `FCSU_CMD_BYTE) ||
            (c == `FCSU_CMD_BURST) || (c == `FCSU_CMD_PAGE) || (c == `FCSU_CMD_WHOLE);
      end
   endfunction

   function is_modify;
      input [7:0] c;
      begin
         is_modify = (c != `FCSU_CMD_BLANK);
      end
   endfunction

   function [15:0] busy_time;
      input [7:0] c;
      begin
         case (c)
            `FCSU_CMD_BLANK: busy_time = `FCSU_T_BLANK;
            `FCSU_CMD_BYTE: busy_time = `FCSU_T_BYTE;
            `FCSU_CMD_BURST: busy_time = `FCSU_T_BURST;
            `FCSU_CMD_PAGE: busy_time = `FCSU_T_PAGE;
            default: busy_time = `FCSU_T_WHOLE;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase capture
   // Only the low offset bits are kept; upper address bits are not decoded,
   // so the register set aliases across the whole slave window.
   reg wr_pend;
   reg [11:0] a_off;
   wire take = HSEL && HREADY && (HTRANS == `FCSU_HTRANS_NONSEQ);

   always @(posedge MCLK) begin
      if (SYS_RST) begin
         wr_pend <= 1'b0;
         a_off <= 12'h000;
      end else begin
         wr_pend <= take && HWRITE;
         if (take) begin
            a_off <= HADDR[11:0];
         end
      end
   end

   // Zero wait states, always OKAY
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   wire wr_status = wr_pend && (a_off == `FCSU_OFF_STATUS);
   wire wr_cmd = wr_pend && (a_off == `FCSU_OFF_COMMAND);
   wire wr_cfg = wr_pend && (a_off == `FCSU_OFF_CONFIG);
   wire wr_prot = wr_pend && (a_off == `FCSU_OFF_PROTECT);
   wire wr_array = wr_pend && (a_off == `FCSU_OFF_ARRAY);
   wire wr_stop = wr_pend && (a_off == `FCSU_OFF_STOP);

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   // Divider and protection setup are plain read/write here; they stand in
   // for the real clock and protection blocks, which sit outside this unit.
   // Protection resets open and disabled so a fresh part can be programmed.
   reg [7:0] cmd;
   reg div_set;
   reg key_mode;
   reg [31:0] protect;
   reg [ADDR_W-1:0] seq_addr;
   reg [7:0] seq_data;
   reg [1:0] seq;

   always @(posedge MCLK) begin
      if (SYS_RST) begin
         div_set <= 1'b0;
         key_mode <= 1'b0;
         protect <= `FCSU_RST_PROTECT;
      end else begin
         if (wr_cfg) begin
            div_set <= HWDATA[`FCSU_BIT_DIVSET];
            key_mode <= HWDATA[`FCSU_BIT_KEYMODE];
         end
         if (wr_prot) begin
            protect <= HWDATA;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags, sequence tracker, execution engine
   // The engine holds one running command and at most one queued burst.
   // A launch is judged in the cycle of the status write data phase:
   // access errors win over protection, and a command that fails either
   // check never reaches the array. The empty flag is lowered by every
   // launch and raised again when the command is dropped, a burst starts or is handed over, or a command finishes.
   reg bef;
   reg pviol;
   reg accerr;
   reg blank;
   reg busy;
   reg [15:0] cnt;
   reg queued;
   reg [7:0] q_cmd;
   reg [ADDR_W-1:0] q_addr;
   reg [7:0] q_data;
   reg start;
   reg [7:0] run_cmd;
   reg [ADDR_W-1:0] run_addr;
   reg [7:0] run_data;

   wire [ADDR_W-1:0] prot_lo = {protect[`FCSU_PROT_LO_MSB:`FCSU_PROT_LO_LSB], {(ADDR_W-8){1'b0}}};
   wire whole_locked = !protect[`FCSU_BIT_OPEN];
   wire block_locked = !protect[`FCSU_BIT_PDIS] && (seq_addr >= prot_lo);
   wire launch = wr_status && HWDATA[`FCSU_BIT_BEF] && bef;
   // Key window takes key data only in key mode
   wire in_key = (seq_addr >= `FCSU_KEY_LO) && (seq_addr <= `FCSU_KEY_HI);
   wire key_write = wr_array && key_mode && (HWDATA[31:16] >= `FCSU_KEY_LO) &&
      (HWDATA[31:16] <= `FCSU_KEY_HI);
   wire seq_bad = (seq != SEQ_CMD) || !div_set || (key_mode && in_key);
   wire cmd_bad = !is_legal(cmd);
   wire busy_bad = busy && !(cmd == `FCSU_CMD_BURST && run_cmd == `FCSU_CMD_BURST);
   wire acc_hit = launch && (seq_bad || cmd_bad || busy_bad);
   wire prot_hit = launch && !acc_hit && is_modify(cmd) &&
      (whole_locked || block_locked);
   wire good = launch && !acc_hit && !prot_hit;
   wire stop_hit = wr_stop && busy;
   // Last busy cycle; the next edge idles or hands over the queue, but a burst queued in this cycle holds it one cycle more
   wire finish = busy && (cnt == `FCSU_CNT_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // Sequence tracker
   // Remembers how far software got through data, command, launch.
   // A command write without a fresh array write drops back to idle,
   // so a stale address can never be launched a second time.

   always @(posedge MCLK) begin
      if (SYS_RST) begin
         cmd <= `FCSU_RST_CMD;
         seq <= SEQ_IDLE;
         seq_addr <= {ADDR_W{1'b0}};
         seq_data <= 8'h00;
      end else begin
         if (wr_array && !key_write) begin
            seq <= SEQ_DATA;
            seq_addr <= HWDATA[`FCSU_ADDR_LSB +: ADDR_W];
            seq_data <= HWDATA[7:0];
         end else if (wr_cmd) begin
            cmd <= HWDATA[7:0];
            seq <= (seq == SEQ_DATA) ? SEQ_CMD : SEQ_IDLE;
         end else if (launch) begin
            seq <= SEQ_IDLE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags and execution
   // Sticky error flags let a hardware set beat a same-cycle software clear,
   // so an error raised by the very write that clears it is never lost.
   // Stop entry aborts both the running and the queued command at once.
   always @(posedge MCLK) begin
      if (SYS_RST) begin
         bef <= 1'b1;
         pviol <= 1'b0;
         accerr <= 1'b0;
         blank <= 1'b0;
         busy <= 1'b0;
         cnt <= 16'd0;
         queued <= 1'b0;
         q_cmd <= 8'h00;
         q_addr <= {ADDR_W{1'b0}};
         q_data <= 8'h00;
         start <= 1'b0;
         run_cmd <= 8'h00;
         run_addr <= {ADDR_W{1'b0}};
         run_data <= 8'h00;
      end else begin
         start <= 1'b0;
         if (prot_hit) begin
            pviol <= 1'b1;
         end else if (wr_status && HWDATA[`FCSU_BIT_PVIOL]) begin
            pviol <= 1'b0;
         end
         if (acc_hit || stop_hit) begin
            accerr <= 1'b1;
         end else if (wr_status && HWDATA[`FCSU_BIT_ACCERR]) begin
            accerr <= 1'b0;
         end
         if (good) begin
            blank <= 1'b0;
         end else if (finish && run_cmd == `FCSU_CMD_BLANK) begin
            blank <= ARRAY_ERASED;
         end
         if (launch) begin
            bef <= 1'b0;
         end
         if (stop_hit) begin
            busy <= 1'b0;
            queued <= 1'b0;
            bef <= 1'b1;
            cnt <= 16'd0;
         end else if (good && !busy) begin
            busy <= 1'b1;
            start <= 1'b1;
            run_cmd <= cmd;
            run_addr <= seq_addr;
            run_data <= seq_data;
            cnt <= busy_time(cmd);
            bef <= (cmd == `FCSU_CMD_BURST) ? 1'b1 : 1'b0;
         end else if (good) begin
            queued <= 1'b1;
            q_cmd <= cmd;
            q_addr <= seq_addr;
            q_data <= seq_data;
         end else if (finish && queued) begin
            queued <= 1'b0;
            start <= 1'b1;
            run_cmd <= q_cmd;
            run_addr <= q_addr;
            run_data <= q_data;
            cnt <= busy_time(q_cmd);
            bef <= 1'b1;
         end else if (finish) begin
            busy <= 1'b0;
            cnt <= 16'd0;
            bef <= 1'b1;
         end else if (busy) begin
            cnt <= cnt - 16'd1;
         end
         // Discarded command leaves buffer empty, even while busy
         if (acc_hit || prot_hit) begin
            bef <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data
   // Decoded from the address phase and registered, so HRDATA comes from a
   // flip-flop. Trade-off: a read pipelined right behind a status write sees
   // the flags as they stood before that write lands.
   // Complete derived from idle and empty
   wire ccf = bef && !busy && !queued;
   wire rd_take = take && !HWRITE;
   reg [31:0] rdata;
   reg [31:0] next_rdata;

   // Register mux on the incoming address
   always @* begin
      next_rdata = 32'h0000_0000;
      case (HADDR[11:0])
         `FCSU_OFF_STATUS: next_rdata[7:0] = {bef, ccf, pviol, accerr, 1'b0, blank, 2'b00};
         `FCSU_OFF_COMMAND: next_rdata[7:0] = cmd;
         `FCSU_OFF_CONFIG: next_rdata[1:0] = {key_mode, div_set};
         `FCSU_OFF_PROTECT: next_rdata = protect;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read word is valid only in a read data phase, zero otherwise
   always @(posedge MCLK) begin
      if (SYS_RST) begin
         rdata <= 32'h0000_0000;
      end else if (rd_take) begin
         rdata <= next_rdata;
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   // All array-side outputs are registered copies of the running command.
   assign HRDATA = rdata;
   assign ARRAY_START = start;
   assign ARRAY_CMD = run_cmd;
   assign ARRAY_ADDR = run_addr;
   assign ARRAY_DATA = run_data;
   assign ARRAY_BUSY = busy;
endmodule

/* File: core/fcsu_defs.vh */
// Constants for the flash command and status unit
`ifndef FCSU_DEFS_VH
`define FCSU_DEFS_VH
// Register byte offsets
`define FCSU_OFF_STATUS 12'h000
`define FCSU_OFF_COMMAND 12'h004
`define FCSU_OFF_CONFIG 12'h008
`define FCSU_OFF_PROTECT 12'h00c
`define FCSU_OFF_ARRAY 12'h010
`define FCSU_OFF_STOP 12'h014
// Status bit positions
`define FCSU_BIT_BEF 7
`define FCSU_BIT_CCF 6
`define FCSU_BIT_PVIOL 5
`define FCSU_BIT_ACCERR 4
`define FCSU_BIT_BLANK 2
// Config bit positions
`define FCSU_BIT_DIVSET 0
`define FCSU_BIT_KEYMODE 1
// Protect register fields
`define FCSU_BIT_OPEN 0
`define FCSU_BIT_PDIS 1
`define FCSU_PROT_LO_MSB 15
`define FCSU_PROT_LO_LSB 8
// Command codes
`define FCSU_CMD_BLANK 8'h05
`define FCSU_CMD_BYTE 8'h20
`define FCSU_CMD_BURST 8'h25
`define FCSU_CMD_PAGE 8'h40
`define FCSU_CMD_WHOLE 8'h41
// Key window bounds
`define FCSU_KEY_LO 16'hffb0
`define FCSU_KEY_HI 16'hffb7
// Array write word: address field starts here
`define FCSU_ADDR_LSB 16
// Count value on the last busy cycle
`define FCSU_CNT_LAST 16'd1
// Reset values
`define FCSU_RST_PROTECT 32'h0000_0003
`define FCSU_RST_CMD 8'h00
// Busy times in cycles
`define FCSU_T_BYTE 16'd45
`define FCSU_T_BURST 16'd20
`define FCSU_T_PAGE 16'd4000
`define FCSU_T_WHOLE 16'd20000
`define FCSU_T_BLANK 16'd64
// AHB transfer type
`define FCSU_HTRANS_NONSEQ 2'b10
`endif

/* File: dv/fcsu_array_model.sv */
// Flash array stand-in that tracks whether every byte reads erased
`timescale 1ns/1ps
module fcsu_array_model (
   input wire clk,
   input wire rst,
   input wire start,
   input wire [7:0] cmd,
   input wire [7:0] data,
   output reg erased
);
   // all-FF state
   // Page erase leaves other pages, so only whole erase sets it
   always @(posedge clk) begin
      if (rst)
         erased <= 1'b0;
      else if (start && cmd == 8'h41)
         erased <= 1'b1;
      else if (start && cmd[7:4] == 4'h2 && data != 8'hff)
         erased <= 1'b0;
   end
endmodule

/* File: dv/fcsu_top_assertions.sv */
// Port-level checks for the flash command unit
`timescale 1ns/1ps
module fcsu_top_assertions #(
   parameter ADDR_W = 16
) (
   input wire MCLK,
   input wire SYS_RST,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   input wire [31:0] HRDATA,
   input wire HREADYOUT,
   input wire HRESP,
   input wire ARRAY_START,
   input wire [7:0] ARRAY_CMD,
   input wire [ADDR_W-1:0] ARRAY_ADDR,
   input wire [7:0] ARRAY_DATA,
   input wire ARRAY_ERASED,
   input wire ARRAY_BUSY
);
   reg aw, ar, dv, op, pd;
   reg [11:0] aa;
   reg [7:0] pl;
   wire go = HSEL && HREADY && HTRANS == 2'b10;
   wire sr = ar && aa == 12'h000;
   wire pe = ARRAY_START && ARRAY_CMD != 8'h05;
   default clocking @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   ////////////////////////////////////////
   // Shadow of divider and protect setup, taken in write data phase
   always @(posedge MCLK) begin
      if (SYS_RST) begin
         {aw, ar, dv, op, pd, pl, aa} <= {3'b000, 2'b11, 20'h0};
      end else begin
         aw <= go && HWRITE;
         ar <= go && !HWRITE;
         if (go)
            aa <= HADDR[11:0];
         if (aw && aa == 12'h008)
            dv <= HWDATA[0];
         if (aw && aa == 12'h00c)
            {pl, pd, op} <= {HWDATA[15:8], HWDATA[1:0]};
      end
   end
   ////////////////////////////////////////
   sequence s_go; ARRAY_START; endsequence
   property p_pulse; s_go |=> !ARRAY_START; endproperty
   a_pulse: assert property (p_pulse) else $error("start too long");
   property p_run; s_go |-> ##[0:1] ARRAY_BUSY; endproperty
   a_run: assert property (p_run) else $error("no busy");
   property p_code; s_go |-> ARRAY_CMD inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}; endproperty
   a_code: assert property (p_code) else $error("bad code");
   property p_div; pe |-> dv; endproperty
   a_div: assert property (p_div) else $error("no divider");
   property p_open; pe |-> op; endproperty
   a_open: assert property (p_open) else $error("closed array");
   property p_prot; pe && !pd && ARRAY_CMD[7:4] == 4'h2 |-> ARRAY_ADDR < {pl, 8'h00}; endproperty
   a_prot: assert property (p_prot) else $error("protected");
   property p_queue; ARRAY_START && $past(ARRAY_BUSY) |-> ARRAY_CMD == 8'h25; endproperty
   a_queue: assert property (p_queue) else $error("queued");
   property p_zero; sr |-> HRDATA[31:8] == 0 && HRDATA[3] == 0 && HRDATA[1:0] == 0; endproperty
   a_zero: assert property (p_zero) else $error("bits set");
   property p_ccf; sr && ARRAY_BUSY && $past(ARRAY_BUSY) |-> !HRDATA[6]; endproperty
   a_ccf: assert property (p_ccf) else $error("done early");
endmodule
bind fcsu_top fcsu_top_assertions #(.ADDR_W(ADDR_W)) u_chk (.MCLK(MCLK), .SYS_RST(SYS_RST),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
   .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .ARRAY_START(ARRAY_START), .ARRAY_CMD(ARRAY_CMD),
   .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_DATA(ARRAY_DATA), .ARRAY_ERASED(ARRAY_ERASED),
   .ARRAY_BUSY(ARRAY_BUSY));

/* File: dv/tb.sv */
// Self-checking bench for the flash command unit
`timescale 1ns/1ps
module tb;
   reg mclk, srst, hsel, hwrite;
   reg [1:0] htrans;
   reg [31:0] haddr, hwdata, rdv;
   reg [55:0] cl = 56'h41_05_20_05_25_40_33;
   reg [55:0] el = 56'hc0_c4_c0_c0_c0_c0_d0;
   wire [31:0] hrdata;
   wire hready, a_start, a_busy, a_erased;
   wire [7:0] a_cmd, a_data;
   wire [15:0] a_addr;
   integer err_total, compares, i;
   fcsu_top u_fcsu_top (.MCLK(mclk), .SYS_RST(srst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(), .ARRAY_START(a_start),
      .ARRAY_CMD(a_cmd), .ARRAY_ADDR(a_addr), .ARRAY_DATA(a_data),
      .ARRAY_ERASED(a_erased), .ARRAY_BUSY(a_busy));
   fcsu_array_model u_fcsu_array_model (.clk(mclk), .rst(srst), .start(a_start),
      .cmd(a_cmd), .data(a_data), .erased(a_erased));
   ////////////////////////////////////////
   task tally_and_finish;
      begin
         $display("compares %0d mismatches %0d", compares, err_total);
         if (err_total == 0 && compares > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task tmo;
      begin
         err_total = err_total + 1;
         $display("CHECK FAILED %0t timeout", $time);
         tally_and_finish;
      end
   endtask
   // Bounded wait for hready at a rising edge
   task rdy;
      integer n;
      begin
         n = 0;
         @(posedge mclk);
         while (hready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n = n + 1;
         end
         if (hready !== 1'b1)
            tmo;
      end
   endtask
   // One single word transfer, read data kept in rdv
   task xf(input w, input [11:0] a, input [31:0] d);
      begin
         hwrite <= w;
         haddr <= {20'h0, a};
         htrans <= 2'b10;
         rdy;
         htrans <= 2'b00;
         hwdata <= d;
         rdy;
         rdv = hrdata;
      end
   endtask
   task st(input [7:0] e);
      begin
         xf(0, 12'h000, 0);
         chk(rdv, {24'h0, e});
      end
   endtask
   task go(input [7:0] c, input [15:0] a);
      begin
         xf(1, 12'h010, {a, 16'h0000});
         xf(1, 12'h004, {24'h0, c});
         xf(1, 12'h000, 32'h80);
      end
   endtask
   // Poll the complete flag; whole erase is the longest wait
   task done;
      integer n;
      begin
         n = 0;
         xf(0, 12'h000, 0);
         while (rdv[6] !== 1'b1 && n < 12000) begin
            xf(0, 12'h000, 0);
            n = n + 1;
         end
         if (rdv[6] !== 1'b1)
            tmo;
      end
   endtask
   ////////////////////////////////////////
   task t_seq;
      begin
         st(8'hc0);
         xf(1, 12'h000, 32'h4f);
         st(8'hc0);
         go(8'h20, 16'h0100);
         done;
         st(8'hd0);
         xf(1, 12'h000, 0);
         st(8'hd0);
         xf(1, 12'h000, 32'h10);
         st(8'hc0);
         xf(1, 12'h008, 1);
         xf(1, 12'h004, 32'h20);
         xf(1, 12'h000, 32'h80);
         done;
         st(8'hd0);
         xf(1, 12'h000, 32'h30);
         $display("t_seq done");
      end
   endtask
   task t_cmds;
      begin
         for (i = 0; i < 7; i = i + 1) begin
            go(cl[55-8*i -: 8], 16'h0100);
            xf(0, 12'h000, 0);
            if (i < 6)
               chk({rdv[6], rdv[2]}, 0);
            done;
            st(el[55-8*i -: 8]);
         end
         xf(1, 12'h000, 32'h10);
         $display("t_cmds done");
      end
   endtask
   task t_prot;
      begin
         xf(1, 12'h00c, 32'h8001);
         go(8'h20, 16'h9000);
         done;
         st(8'he0);
         xf(1, 12'h000, 32'h10);
         st(8'he0);
         xf(1, 12'h000, 32'h20);
         st(8'hc0);
         xf(1, 12'h00c, 32'h2);
         go(8'h40, 16'h0100);
         done;
         st(8'he0);
         xf(1, 12'h000, 32'h20);
         xf(1, 12'h00c, 32'h3);
         $display("t_prot done");
      end
   endtask
   task t_burst;
      begin
         go(8'h25, 16'h0200);
         go(8'h25, 16'h0201);
         xf(0, 12'h000, 0);
         chk(rdv[7:6], 0);
         done;
         st(8'hc0);
         go(8'h25, 16'h0202);
         go(8'h20, 16'h0203);
         done;
         st(8'hd0);
         xf(1, 12'h000, 32'h10);
         go(8'h40, 16'h0400);
         xf(1, 12'h014, 0);
         done;
         st(8'hd0);
         xf(1, 12'h000, 32'h10);
         $display("t_burst done");
      end
   endtask
   ////////////////////////////////////////
   initial begin
      mclk = 0;
      forever #20 mclk = ~mclk;
   end
   // Reset, then the scenarios in order
   initial begin
      {srst, hsel, hwrite, htrans, haddr, hwdata, rdv} = {3'b110, 98'h0};
      err_total = 0;
      compares = 0;
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      t_seq;
      t_cmds;
      t_prot;
      t_burst;
      tally_and_finish;
   end
endmodule
